/* File: rtl/isp_top.sv */
/*
  Interrupt status, source assignment and priority unit with an APB slave.
  Assumes request lines are level signals synchronous to clk_sys, and a CPU
  that pulses cpu_ack when it takes the vector and drives its own enable flag.
*/
// Functional notes
// RL1: The low status register is read only and writes never change it.
// RL2: Both status registers show raw request levels whatever the masks hold.
// RL3: Low status bits 15 to 1 follow request lines 15 to 1.
// RL4: Low status bit 0 always reads zero since line 0 has no source.
// RL5: High status bits 15 to 0 follow request lines 31 to 16; the code ties bits 14 to 9 and 3 (unused lines 30-25, 19) to zero.
// RL6: A status bit is 1 while its source requests and 0 while idle.
// RL7: Pending lines are ranked by number with line 31 highest.
// RL8: Lines 31, 24, 23-20, 18, 17, 16 carry timer 0, USB, DMA 0-3, audio, UART rx, codec.
// RL9: Lines 15 to 1 carry two-wire bus, timers, versatile timer, serial, UART, wakeup, flash.
// RL10: Software points every unused vector at a default handler.
// RL11: A non-maskable request always reaches the CPU, even inside any handler.
// RL12: Maskable requests do not nest until the handler sets the CPU enable flag.
// RL13: Software clears non-nestable source enables before setting that flag.
// RL14: Nesting depth has no limit in this unit.
// RL15: The vector is 10h plus the highest line both asserted and enabled.
// RL16: Both source mask registers reset to all ones.
// RL17: Status follows the request inputs every cycle with no latching.
`timescale 1ns/1ps
`default_nettype none

`include "isp_defs.svh"

module isp_top
  import isp_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rstn,
  input  wire isp_apb_req_type apb_req,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // 31 timer 0, 24 USB, 23-20 DMA 0-3, 18 audio, 17 UART rx, 16 codec,
  // 15 two-wire bus, 14/13 timer inputs A/B, 12-9 versatile timer 1-4,
  // 8 serial, 7/6 UART tx/cts, 5-2 wakeup 0-3, 1 flash; others unused
  input  wire logic [31:0]     irq_req,
  input  wire logic            nmi_req,
  input  wire logic            nmi_ack,
  input  wire logic            cpu_ie,
  input  wire logic            cpu_ack,
  output logic [7:0]           vector_register,
  output logic                 int_to_cpu,
  output logic                 nmi_to_cpu,
  output logic                 irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic isp_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    return addr == off;
  endfunction : isp_hit
  function automatic logic [4:0] isp_encode(input logic [31:0] act);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 1; i < 32; i++) begin
      if (act[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : isp_encode

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [31:0]           request_active_bits;
  logic [15:0]           irq_status_low;
  logic [15:0]           irq_status_high;
  logic [15:0]           source_mask_low;
  logic [15:0]           source_mask_high;
  logic [31:0]           source_enable_bits;
  logic [31:0]           enabled_pending;
  logic [7:0]            next_vector;
  logic [`ISP_EVT_W-1:0] evt_status;
  logic [`ISP_EVT_W-1:0] evt_mask;
  logic [`ISP_EVT_W-1:0] evt_set;
  logic [`ISP_EVT_W-1:0] evt_clr;
  logic [31:0]           rd_val;
  logic                  setup;
  logic                  access;
  logic                  mapped;
  logic                  wr_en;
  logic                  rd_done;
  logic                  pend_any;
  logic                  pend_q;
  logic                  nmi_q;
  logic                  nmi_rise;
  logic                  nmi_pend;
  logic                  ie_q;
  logic                  ie_rise;
  logic                  nest_block;
  logic                  mask_written;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign setup   = apb_req.psel && !apb_req.penable;
  assign access  = apb_req.psel && apb_req.penable;
  assign mapped  = apb_req.paddr inside {`ISP_OFF_STAT_LO, `ISP_OFF_STAT_HI,
                                         `ISP_OFF_MASK_LO, `ISP_OFF_MASK_HI, `ISP_OFF_VECTOR,
                                         `ISP_OFF_EVT, `ISP_OFF_EVT_MASK};
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_en   = access && apb_req.pwrite && mapped;
  assign rd_done = access && !apb_req.pwrite;

  // ----------------------------------------------------------------
  // Request sampling and status view
  // ----------------------------------------------------------------
  // Unused lines are tied off so they never show or win
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      request_active_bits <= 32'h0000_0000;
    end else begin
      request_active_bits <= irq_req & {`ISP_USED_HI, `ISP_USED_LO}; // see RL17, RL8, RL9
    end
  end

  assign irq_status_low  = request_active_bits[`ISP_HALF_W-1:0];  // see RL3, RL4, RL6
  assign irq_status_high = request_active_bits[31:`ISP_HALF_W];   // see RL5, RL2

  // ----------------------------------------------------------------
  // Source masks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      source_mask_low  <= `ISP_MASK_RST; // see RL16
      source_mask_high <= `ISP_MASK_RST; // see RL16
    end else if (wr_en) begin
      if (isp_hit(apb_req.paddr, `ISP_OFF_MASK_LO)) begin
        source_mask_low <= apb_req.pwdata[15:0];
      end
      if (isp_hit(apb_req.paddr, `ISP_OFF_MASK_HI)) begin
        source_mask_high <= apb_req.pwdata[15:0];
      end
    end
  end

  assign source_enable_bits = {source_mask_high, source_mask_low[15:1], 1'b0};
  assign enabled_pending    = request_active_bits & source_enable_bits;

  // ----------------------------------------------------------------
  // Priority encoder and vector
  // ----------------------------------------------------------------
  // Highest line wins; nothing pending gives the base vector
  assign next_vector = `ISP_VEC_BASE + {3'b000, isp_encode(enabled_pending)}; // see RL7, RL15
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vector_register <= `ISP_VEC_BASE;
    end else begin
      vector_register <= next_vector; // see RL15
    end
  end

  // ----------------------------------------------------------------
  // Nesting control
  // ----------------------------------------------------------------
  assign ie_rise = cpu_ie && !ie_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ie_q <= 1'b0;
    end else begin
      ie_q <= cpu_ie;
    end
  end

  // A taken vector blocks further maskable requests until the handler
  // raises the enable flag again; one bit suffices at any depth
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nest_block <= 1'b0;
    end else if (cpu_ack) begin
      nest_block <= 1'b1; // see RL12
    end else if (ie_rise) begin
      nest_block <= 1'b0; // see RL12, RL14
    end
  end

  assign int_to_cpu = (|enabled_pending) && cpu_ie && !nest_block; // see RL12

  // ----------------------------------------------------------------
  // Non-maskable path
  // ----------------------------------------------------------------
  assign nmi_rise = nmi_req && !nmi_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nmi_q    <= 1'b0;
      nmi_pend <= 1'b0;
    end else begin
      nmi_q <= nmi_req;
      if (nmi_rise) begin
        nmi_pend <= 1'b1; // see RL11
      end else if (nmi_ack) begin
        nmi_pend <= 1'b0;
      end
    end
  end

  // Never gated by the nesting block or the enable flag
  assign nmi_to_cpu = nmi_pend; // see RL11

  // ----------------------------------------------------------------
  // Event status and interrupt output
  // ----------------------------------------------------------------
  assign pend_any = |enabled_pending;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_any;
    end
  end
  always_comb begin
    evt_set                = '0;
    evt_set[`ISP_EVT_REQ]  = pend_any && !pend_q;
    evt_set[`ISP_EVT_SPUR] = cpu_ack && (vector_register == `ISP_VEC_BASE);
    evt_set[`ISP_EVT_NMI]  = nmi_rise;
    evt_clr                = '0;
    if (rd_done && isp_hit(apb_req.paddr, `ISP_OFF_EVT)) begin
      evt_clr = '1;
    end
  end

  // A new event in the clearing read cycle stays set
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_status <= '0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_mask <= '0;
    end else if (wr_en && isp_hit(apb_req.paddr, `ISP_OFF_EVT_MASK)) begin
      evt_mask <= apb_req.pwdata[`ISP_EVT_W-1:0];
    end
  end
  assign irq = |(evt_status & evt_mask);

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    case (apb_req.paddr)
      `ISP_OFF_STAT_LO:  rd_val[15:0]           = irq_status_low;  // see RL1
      `ISP_OFF_STAT_HI:  rd_val[15:0]           = irq_status_high; // see RL1
      `ISP_OFF_MASK_LO:  rd_val[15:0]           = source_mask_low;
      `ISP_OFF_MASK_HI:  rd_val[15:0]           = source_mask_high;
      `ISP_OFF_VECTOR:   rd_val[7:0]            = vector_register;
      `ISP_OFF_EVT:      rd_val[`ISP_EVT_W-1:0] = evt_status;
      `ISP_OFF_EVT_MASK: rd_val[`ISP_EVT_W-1:0] = evt_mask;
      default:           rd_val                 = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !apb_req.pwrite) begin
      prdata <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mask_written <= 1'b0;
    end else if (wr_en && (isp_hit(apb_req.paddr, `ISP_OFF_MASK_LO)
                        || isp_hit(apb_req.paddr, `ISP_OFF_MASK_HI))) begin
      mask_written <= 1'b1;
    end
  end

  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence s_read_setup(logic [7:0] off);
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == off;
  endsequence
  sequence s_write_access(logic [7:0] off);
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == off;
  endsequence
  a_low_read_raw: assert property ( // see RL3, RL6, RL17
    s_read_setup(`ISP_OFF_STAT_LO) |=>
      prdata[15:0] == {$past(irq_req[15:1], 2), 1'b0} && prdata[31:16] == 16'h0000)
    else $error("low status read does not match request lines");
  a_high_read_raw: assert property ( // see RL5, RL8
    s_read_setup(`ISP_OFF_STAT_HI) |=>
      prdata[15:0] == ($past(irq_req[31:16], 2) & `ISP_USED_HI))
    else $error("high status read does not match request lines");
  a_bit0_zero: assert property ( // see RL4
    irq_status_low[0] == 1'b0)
    else $error("low status bit 0 is not zero");
  a_status_ro: assert property ( // see RL1
    s_write_access(`ISP_OFF_STAT_LO) ##1 irq_req[15:1] == $past(irq_req[15:1]) |=>
      irq_status_low[15:1] == $past(irq_req[15:1], 2))
    else $error("write disturbed low status");
  a_mask_blind: assert property ( // see RL2
    (source_mask_low[5] == 1'b0 && irq_req[5]) |=> irq_status_low[5])
    else $error("status hidden by a cleared source mask");
  a_top_wins: assert property ( // see RL7, RL15
    irq_req[31] ##1 source_mask_high[15] |=> vector_register == `ISP_VEC_TOP)
    else $error("line 31 did not give the top vector");
  a_linear_prio: assert property ( // see RL7
    (irq_req[24] && irq_req[16] && !irq_req[31])
      ##1 (source_mask_high[8] && source_mask_high[0] && !request_active_bits[31]) |=>
      vector_register == 8'h28)
    else $error("line 24 did not win over line 16");
  a_vector_range: assert property ( // see RL15
    vector_register >= `ISP_VEC_BASE && vector_register <= `ISP_VEC_TOP)
    else $error("vector out of range");
  a_mask_reset: assert property ( // see RL16
    !mask_written |-> source_mask_low == `ISP_MASK_RST && source_mask_high == `ISP_MASK_RST)
    else $error("source masks lost their reset value");
  a_nmi_preempt: assert property ( // see RL11
    (nmi_req && !nmi_q) |=> nmi_to_cpu)
    else $error("non-maskable request not passed on");
  a_no_nest: assert property ( // see RL12
    cpu_ack |=> !int_to_cpu)
    else $error("maskable request nested without enable flag");
  a_nest_reopen: assert property ( // see RL12, RL14
    (nest_block && cpu_ie && !ie_q && !cpu_ack) |=> !nest_block)
    else $error("enable flag did not reopen nesting");

endmodule : isp_top

`default_nettype wire

/* File: rtl/isp_defs.svh */
/*
  Constants of the interrupt status and priority block: register offsets,
  reset values, vector encoding, event bit positions and source wiring.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISP_OFF_STAT_LO  8'h00
`define ISP_OFF_STAT_HI  8'h04
`define ISP_OFF_MASK_LO  8'h08
`define ISP_OFF_MASK_HI  8'h0C
`define ISP_OFF_VECTOR   8'h10
`define ISP_OFF_EVT      8'h14
`define ISP_OFF_EVT_MASK 8'h18

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define ISP_MASK_RST     16'hFFFF
`define ISP_VEC_BASE     8'h10
`define ISP_VEC_TOP      8'h2F
`define ISP_USED_HI      16'h81F7
`define ISP_USED_LO      16'hFFFE
`define ISP_HALF_W       16

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define ISP_EVT_W        3
`define ISP_EVT_REQ      0
`define ISP_EVT_SPUR     1
`define ISP_EVT_NMI      2

`endif

/* File: rtl/isp_pkg.sv */
/*
  Types of the interrupt status and priority block.
  Assumes isp_defs.svh is on the include path.
*/
`include "isp_defs.svh"

package isp_pkg;

  // ----------------------------------------------------------------
  // APB request bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } isp_apb_req_type;

endpackage : isp_pkg

/* File: testbench/isp_cpu_model.sv */
/*
  CPU core model: takes vectored interrupts and NMIs from isp_top.
  Assumes the bench drives ie_allow, nest and ack_delay (2 or more).
*/
`timescale 1ns/1ps
`default_nettype none

`include "isp_defs.svh"

module isp_cpu_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       int_to_cpu,
  input  wire logic       nmi_to_cpu,
  input  wire logic [7:0] vector_register,
  input  wire logic       ie_allow,
  input  wire logic       nest,
  input  wire logic [3:0] ack_delay,
  output logic            cpu_ie,
  output logic            cpu_ack,
  output logic            nmi_ack,
  output logic [7:0]      last_vec,
  output logic [7:0]      ack_count,
  output logic [7:0]      nmi_count,
  output logic [7:0]      default_hits
);
  logic [3:0] wait_cnt;
  logic       in_isr;

  // ----------------------------------------------------------------
  // Acknowledge, handler entry and NMI service
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_ie    <= 1'b0;
      cpu_ack   <= 1'b0;
      nmi_ack   <= 1'b0;
      last_vec  <= 8'h00;
      ack_count <= 8'h00;
      nmi_count <= 8'h00;
      default_hits <= 8'h00;
      wait_cnt  <= 4'h0;
      in_isr    <= 1'b0;
    end else begin
      cpu_ack  <= 1'b0;
      wait_cnt <= (int_to_cpu && cpu_ie) ? wait_cnt + 4'h1 : 4'h0;
      nmi_ack  <= nmi_to_cpu && !nmi_ack;
      if (nmi_to_cpu && !nmi_ack) begin
        nmi_count <= nmi_count + 8'h01;
      end
      if (int_to_cpu && cpu_ie && wait_cnt >= ack_delay) begin
        cpu_ack   <= 1'b1;
        last_vec  <= vector_register;
        in_isr    <= 1'b1;
        wait_cnt  <= 4'h0;
        ack_count <= ack_count + 8'h01;
        // Only the base vector entry is counted as a hit on the one default handler
        if (vector_register == `ISP_VEC_BASE) begin
          default_hits <= default_hits + 8'h01;
        end
      end else begin
        // Flag falls two cycles after the acknowledge, so only the block stops nesting;
        // the handler reopens it only when nesting is allowed
        cpu_ie <= cpu_ack ? cpu_ie : (ie_allow && (!in_isr || nest));
      end
    end
  end
endmodule : isp_cpu_model

`default_nettype wire

/* File: testbench/interrupt_status_priority_test.sv */
/*
  Self-checking bench of isp_top: status, masks, priority, events, nesting.
  Assumes the design files and isp_cpu_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

`include "isp_defs.svh"

module interrupt_status_priority_test
  import isp_pkg::*;
;
  logic            clk_sys;
  logic            rstn;
  isp_apb_req_type apb_req;
  logic [31:0]     prdata;
  logic [31:0]     irq_req;
  logic [31:0]     rd;
  logic [31:0]     exp;
  logic [7:0]      vector_register;
  logic [7:0]      last_vec;
  logic [7:0]      ack_count;
  logic [7:0]      nmi_count;
  logic [7:0]      default_hits;
  logic            pready, pslverr, nmi_req, nmi_ack, cpu_ie, cpu_ack;
  logic            int_to_cpu, nmi_to_cpu, irq, ie_allow, nest, er;
  int              err_count;
  int              total_checks;

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  isp_top u_dut (.clk_sys(clk_sys), .rstn(rstn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .nmi_req(nmi_req),
    .nmi_ack(nmi_ack), .cpu_ie(cpu_ie), .cpu_ack(cpu_ack),
    .vector_register(vector_register), .int_to_cpu(int_to_cpu),
    .nmi_to_cpu(nmi_to_cpu), .irq(irq));

  isp_cpu_model u_cpu (.clk_sys(clk_sys), .rstn(rstn), .int_to_cpu(int_to_cpu),
    .nmi_to_cpu(nmi_to_cpu), .vector_register(vector_register), .ie_allow(ie_allow),
    .nest(nest), .ack_delay(4'h2), .cpu_ie(cpu_ie), .cpu_ack(cpu_ack),
    .nmi_ack(nmi_ack), .last_vec(last_vec), .ack_count(ack_count),
    .nmi_count(nmi_count), .default_hits(default_hits));

  // ----------------------------------------------------------------
  // Bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] got);
    total_checks++;
    if (got !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask : check

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    apb_req <= '0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(a, 1'b0, 32'h0);
    check(what, e, rd);
  endtask : rd_chk

  task automatic set_req(input logic [31:0] v);
    @(posedge clk_sys);
    irq_req <= v;
    repeat (3) @(posedge clk_sys);
  endtask : set_req

  task automatic wait_ack(input logic [7:0] k);
    int n;
    n = 0;
    while (ack_count < k && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check("ack_count", 32'h1, {31'h0, ack_count >= k});
  endtask : wait_ack

  task automatic finish_test;
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    $display("ERROR watchdog expected end seen hang");
    finish_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    apb_req = '0;
    irq_req = 32'h0;
    nmi_req = 1'b0;
    ie_allow = 1'b0;
    nest = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(`ISP_OFF_MASK_LO, 32'h0000FFFF, "mask_low");
    rd_chk(`ISP_OFF_MASK_HI, 32'h0000FFFF, "mask_high");
    for (int n = 0; n < 32; n++) begin
      set_req(32'h1 << n);
      exp = {`ISP_USED_HI, `ISP_USED_LO} & (32'h1 << n);
      rd_chk(`ISP_OFF_STAT_LO, {16'h0, exp[15:0]}, "status_low");
      rd_chk(`ISP_OFF_STAT_HI, {16'h0, exp[31:16]}, "status_high");
      check("vector", (exp != 0) ? 32'h10 + n : 32'h10, {24'h0, vector_register});
    end
    set_req(32'h0000_0008);
    apb(`ISP_OFF_STAT_LO, 1'b1, 32'h0000FFFF);
    rd_chk(`ISP_OFF_STAT_LO, 32'h00000008, "status_low_ro");
    apb(`ISP_OFF_MASK_LO, 1'b1, 32'h0);
    apb(`ISP_OFF_MASK_HI, 1'b1, 32'h0);
    set_req(32'hFFFF_FFFF);
    rd_chk(`ISP_OFF_STAT_LO, 32'h0000FFFE, "status_low_masked");
    rd_chk(`ISP_OFF_STAT_HI, 32'h000081F7, "status_high_masked");
    check("vector_masked", 32'h10, {24'h0, vector_register});
    apb(`ISP_OFF_MASK_LO, 1'b1, 32'h0000FFFF);
    apb(`ISP_OFF_MASK_HI, 1'b1, 32'h0000FEFF);
    set_req(32'h0110_0002);
    check("vector_prio_masked", 32'h24, {24'h0, vector_register});
    apb(`ISP_OFF_MASK_HI, 1'b1, 32'h0000FFFF);
    repeat (3) @(posedge clk_sys);
    check("vector_prio", 32'h28, {24'h0, vector_register});
    set_req(32'h8110_0002);
    check("vector_top", 32'h2F, {24'h0, vector_register});
    apb(8'h1C, 1'b0, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, er});
    check("unmapped_data", 32'h0, rd);
    apb(`ISP_OFF_EVT_MASK, 1'b1, 32'h7);
    rd_chk(`ISP_OFF_EVT_MASK, 32'h7, "event_mask");
    set_req(32'h0);
    apb(`ISP_OFF_EVT, 1'b0, 32'h0);
    @(posedge clk_sys);
    check("irq_cleared", 32'h0, {31'h0, irq});
    set_req(32'h0000_0002);
    check("irq_raised", 32'h1, {31'h0, irq});
    apb(`ISP_OFF_EVT_MASK, 1'b1, 32'h0);
    repeat (2) @(posedge clk_sys);
    check("irq_masked", 32'h0, {31'h0, irq});
    rd_chk(`ISP_OFF_EVT, 32'h1, "event_status");
    rd_chk(`ISP_OFF_EVT, 32'h0, "event_cleared");
    set_req(32'h0);
    ie_allow <= 1'b1;
    set_req(32'h0100_0000);
    wait_ack(8'h01);
    check("taken_vector", 32'h28, {24'h0, last_vec});
    set_req(32'h8100_0000);
    repeat (8) @(posedge clk_sys);
    check("no_nesting", 32'h0, {31'h0, int_to_cpu});
    nmi_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    nmi_req <= 1'b0;
    check("nmi_in_handler", 32'h1, {24'h0, nmi_count});
    apb(`ISP_OFF_MASK_LO, 1'b1, 32'h0);
    nest <= 1'b1;
    wait_ack(8'h02);
    check("nested_vector", 32'h2F, {24'h0, last_vec});
    nmi_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("nmi_nested", 32'h2, {24'h0, nmi_count});
    rd_chk(`ISP_OFF_EVT, 32'h5, "event_nmi");
    check("default_hits", 32'h0, {24'h0, default_hits});
    ie_allow <= 1'b0;
    nmi_req <= 1'b0;
    finish_test();
  end
endmodule : interrupt_status_priority_test

`default_nettype wire
